// ---- design/adc_ctrl_cfg.svh ----
// constants of the multiplexed converter control block
`ifndef ADC_CTRL_CFG_SVH
`define ADC_CTRL_CFG_SVH

// ***************
// timing
// ***************
`define CLK_PERIOD_NS   40
`define SETTLE_TIME_NS  3000
`define SETTLE_CYCLES   ((`SETTLE_TIME_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)

// ***************
// status word bit positions, bus bit 0 is the msb
// ***************
`define SW_EXT_SYNC_BIT   4
`define SW_XFER_MODE_BIT  5
`define SW_MEM_EN_BIT     6
`define SW_GAIN_HI_BIT    7
`define SW_GAIN_LO_BIT    8
`define SW_ADD_MEM_BIT    9
`define SW_SEQ_BIT        10
`define SW_CHAN_FIRST     11
`define SW_CHAN_LAST      17

// ***************
// read-back word layout
// ***************
`define RS_WC_BIT       0
`define RS_MEM_BIT      1
`define RB_FIRST        5
`define RB_LAST         17

// ***************
// subdevice codes
// ***************
`define SUB_DATA        2'h0
`define SUB_STATUS      2'h1
`define SUB_MEMORY      2'h2

// ***************
// reset values
// ***************
`define CHAN_RESET      7'h00
`define RESULT_RESET    13'h0000
`define CTRL_RESET      7'h00
// device select code: the value is arbitrary, set it to the slot in use
`define DEV_CODE_RESET  6'h01

`endif

// ---- design/adc_ctrl_pkg.sv ----
// types of the multiplexed converter control block
package adc_ctrl_pkg;

   // ***************
   // control flip-flops loaded from the status word
   // ***************
   typedef struct packed {
      logic       sequential_mode;
      logic       add_to_memory;
      logic       ext_sync_sel;
      logic       transfer_mode_ff;
      logic       mem_overflow_en;
      logic       gain_bit_high;
      logic       gain_bit_low;
   } ctrl_t;

   // ***************
   // decoded transfer instructions
   // ***************
   typedef enum logic [2:0] {
      INSTR_NONE,
      INSTR_SKIP_DONE,
      INSTR_READ_BUFFER,
      INSTR_CONVERT,
      INSTR_SKIP_WC,
      INSTR_READ_STATUS,
      INSTR_CLEAR_FLAGS,
      INSTR_SKIP_MEM
   } instr_t;

endpackage

// ---- design/multiplexed_adc_interface_control.sv ----
// control logic of the multiplexed converter: sync, channel register, result buffer, decode
`timescale 1ns/1ns
`include "adc_ctrl_cfg.svh"

module multiplexed_adc_interface_control
   import adc_ctrl_pkg::*;
#(
   parameter logic [5:0] DEV_CODE     = `DEV_CODE_RESET, // arbitrary default
   parameter int         MUX_CHANNELS = 128,
   parameter int         SETTLE       = `SETTLE_CYCLES
) (
   input  wire logic        clk_i,
   input  wire logic        rst_n_i,
   input  wire logic [5:0]  dev_sel_i,
   input  wire logic [1:0]  subdev_sel_i,
   input  wire logic        iop1_i,
   input  wire logic        iop2_i,
   input  wire logic        host_to_device_pulse_i,
   input  wire logic [0:17] bus_data_n_i,
   input  wire logic        dch_cycle_i,
   input  wire logic        write_request_i,
   input  wire logic        read_request_i,
   input  wire logic        word_count_overflow_flag_i,
   input  wire logic        mem_overflow_flag_i,
   input  wire logic        ext_sync_i,
   input  wire logic        conv_done_i,
   input  wire logic [12:0] conv_data_i,
   output logic             start_conv_o,
   output logic             settling_o,
   output logic [6:0]       channel_o,
   output logic             channel_valid_o,
   output logic [1:0]       gain_code_o,
   output ctrl_t            ctrl_o,
   output logic             done_flag_o,
   output logic             skip_o,
   output logic             clear_flags_o,
   output logic [0:17]      bus_data_o,
   output logic             bus_data_oe_o
);

   // ***************
   // instruction decode
   // ***************
   function automatic instr_t decode(input logic [1:0] sub, input logic p1,
                                     input logic p2, input logic p4);
      instr_t r;
      r = INSTR_NONE;
      unique case (sub)
         `SUB_DATA: begin
            if (p1)
               r = INSTR_SKIP_DONE;
            else if (p2)
               r = INSTR_READ_BUFFER;
            else if (p4)
               r = INSTR_CONVERT;
         end
         `SUB_STATUS: begin
            if (p1)
               r = INSTR_SKIP_WC;
            else if (p2)
               r = INSTR_READ_STATUS;
            else if (p4)
               r = INSTR_CLEAR_FLAGS;
         end
         `SUB_MEMORY: begin
            if (p1)
               r = INSTR_SKIP_MEM;
         end
         default: r = INSTR_NONE;
      endcase
      return r;
   endfunction

   logic   addressed_w;
   logic   dma_active_w;
   instr_t instr_w;
   logic   convert_instr;
   logic   read_status_instr;
   logic   read_buffer_w;

   // direct transfers do not carry an instruction, so decode is held off
   assign dma_active_w  = dch_cycle_i;
   assign addressed_w   = (dev_sel_i == DEV_CODE) && !dma_active_w;
   assign instr_w       = addressed_w ? decode(subdev_sel_i, iop1_i, iop2_i,
                                               host_to_device_pulse_i) : INSTR_NONE;
   assign convert_instr     = (instr_w == INSTR_CONVERT);
   assign read_status_instr = (instr_w == INSTR_READ_STATUS);
   assign read_buffer_w     = (instr_w == INSTR_READ_BUFFER);

   // ***************
   // load and select clock
   // ***************
   logic  add_cycle_w;
   logic  load_w;
   logic  select_clock_w;
   logic  dch_read_w;
   ctrl_t ctrl_r;
   ctrl_t ctrl_nxt;
   logic [0:17] bus_true_w;

   assign bus_true_w  = ~bus_data_n_i;
   assign add_cycle_w = write_request_i && read_request_i;
   assign load_w      = dma_active_w && !word_count_overflow_flag_i
                        && host_to_device_pulse_i && !add_cycle_w;
   assign select_clock_w = convert_instr || load_w;
   // data strobe of a direct transfer to memory
   assign dch_read_w  = dma_active_w && iop2_i;

   assign ctrl_nxt.sequential_mode  = bus_true_w[`SW_SEQ_BIT];
   assign ctrl_nxt.add_to_memory    = bus_true_w[`SW_ADD_MEM_BIT];
   assign ctrl_nxt.ext_sync_sel     = bus_true_w[`SW_EXT_SYNC_BIT];
   assign ctrl_nxt.transfer_mode_ff = bus_true_w[`SW_XFER_MODE_BIT];
   assign ctrl_nxt.mem_overflow_en  = bus_true_w[`SW_MEM_EN_BIT];
   assign ctrl_nxt.gain_bit_high    = bus_true_w[`SW_GAIN_HI_BIT];
   assign ctrl_nxt.gain_bit_low     = bus_true_w[`SW_GAIN_LO_BIT];

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         ctrl_r <= `CTRL_RESET;
      else if (select_clock_w)
         ctrl_r <= ctrl_nxt;
   end

   assign ctrl_o      = ctrl_r;
   // binary code: 0,1,2,3 select gain 1,2,4,8
   assign gain_code_o = {ctrl_r.gain_bit_high, ctrl_r.gain_bit_low};

   // ***************
   // channel address register
   // ***************
   logic [6:0] chan_r;
   logic [6:0] chan_nxt;
   logic       count_w;

   assign count_w = conv_done_i && ctrl_r.sequential_mode && ctrl_r.transfer_mode_ff
                    && !word_count_overflow_flag_i;
   // a jam load wins over a count in the same cycle
   assign chan_nxt = select_clock_w ? bus_true_w[`SW_CHAN_FIRST:`SW_CHAN_LAST]
                   : count_w ? chan_r + 7'h01
                   : chan_r;

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         chan_r <= `CHAN_RESET;
      else
         chan_r <= chan_nxt;
   end

   assign channel_o       = chan_r;
   // channels beyond the fitted multiplexer select nothing
   assign channel_valid_o = (32'(chan_r) < MUX_CHANNELS);

   // ***************
   // sync and settling
   // ***************
   logic sel_del_r;
   logic convert_pulse_w;
   logic sync_w;
   logic settle_busy_w;
   logic start_w;
   logic seq_next_w;

   assign seq_next_w = conv_done_i && ctrl_r.sequential_mode && ctrl_r.transfer_mode_ff
                       && !word_count_overflow_flag_i && !mem_overflow_flag_i;
   // the delayed select clock lets the new gain and channel take effect first
   assign convert_pulse_w = sel_del_r || seq_next_w;
   assign sync_w = ctrl_r.ext_sync_sel ? ext_sync_i
                 : (convert_pulse_w && !ctrl_r.ext_sync_sel);

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         sel_del_r <= 1'b0;
      else
         sel_del_r <= select_clock_w;
   end

   settle_timer #(
      .CYCLES (SETTLE)
   ) u_settle (
      .clk_i     (clk_i),
      .rst_n_i   (rst_n_i),
      .trigger_i (sync_w),
      .busy_o    (settle_busy_w),
      .fire_o    (start_w)
   );

   assign start_conv_o = start_w;
   assign settling_o   = settle_busy_w;

   // ***************
   // result buffer and done flag
   // ***************
   logic [12:0] result_r;
   logic        done_r;
   logic        done_clr_w;
   logic        clear_instr_w;
   logic        skip_done_w;
   logic        skip_wc_w;
   logic        skip_mem_w;

   // frozen during memory overflow so the added value can be recovered
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         result_r <= `RESULT_RESET;
      else if (conv_done_i && !mem_overflow_flag_i)
         result_r <= conv_data_i;
   end

   assign clear_instr_w = (instr_w == INSTR_CLEAR_FLAGS);
   assign skip_done_w   = (instr_w == INSTR_SKIP_DONE) && done_r;
   assign skip_wc_w     = (instr_w == INSTR_SKIP_WC) && word_count_overflow_flag_i;
   assign skip_mem_w    = (instr_w == INSTR_SKIP_MEM) && mem_overflow_flag_i;
   assign done_clr_w    = read_buffer_w || convert_instr || clear_instr_w;

   // a done event in the clearing cycle wins
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i)
         done_r <= 1'b0;
      else if (conv_done_i)
         done_r <= 1'b1;
      else if (done_clr_w)
         done_r <= 1'b0;
   end

   assign done_flag_o   = done_r;
   assign clear_flags_o = clear_instr_w;
   // a skip answers inside the pulse cycle, so it cannot come from a flip-flop
   assign skip_o        = skip_done_w || skip_wc_w || skip_mem_w;

   // ***************
   // data drivers
   // ***************
   logic [0:17] rd_word_w;
   logic [0:17] stat_word_w;
   logic [0:17] buf_word_w;
   logic [0:17] data_r;
   logic        oe_r;
   logic        strobe_w;

   always_comb begin
      stat_word_w = 18'h00000;
      stat_word_w[`SW_CHAN_FIRST:`SW_CHAN_LAST] = chan_r;
      stat_word_w[`RS_WC_BIT]  = word_count_overflow_flag_i;
      stat_word_w[`RS_MEM_BIT] = mem_overflow_flag_i;
      buf_word_w = 18'h00000;
      buf_word_w[`RB_FIRST:`RB_LAST] = result_r;
   end

   assign strobe_w  = read_buffer_w || read_status_instr || dch_read_w;
   assign rd_word_w = read_status_instr ? stat_word_w : buf_word_w;

   // one cycle of drive after each strobe, released otherwise
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         data_r <= 18'h00000;
         oe_r   <= 1'b0;
      end else begin
         data_r <= strobe_w ? rd_word_w : 18'h00000;
         oe_r   <= strobe_w;
      end
   end

   assign bus_data_o    = data_r;
   assign bus_data_oe_o = oe_r;

endmodule // multiplexed_adc_interface_control

// ---- design/settle_timer.sv ----
// settling delay timer: a start pulse after a fixed count
`timescale 1ns/1ns
module settle_timer #(
   parameter int CYCLES = 75
) (
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   input  wire logic trigger_i,
   output logic      busy_o,
   output logic      fire_o
);

   localparam int W = $clog2(CYCLES + 1);
   localparam logic [W-1:0] LAST = W'(CYCLES);

   logic [W-1:0] cnt_r;
   logic         run_r;
   logic         fire_r;
   logic         done_w;

   assign done_w = run_r && (cnt_r == LAST);
   assign busy_o = run_r;
   assign fire_o = fire_r;

   // a new trigger restarts the delay so the last sync always settles fully
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         cnt_r  <= '0;
         run_r  <= 1'b0;
         fire_r <= 1'b0;
      end else begin
         fire_r <= done_w && !trigger_i;
         if (trigger_i) begin
            cnt_r <= W'(1);
            run_r <= 1'b1;
         end else if (done_w) begin
            run_r <= 1'b0;
         end else if (run_r) begin
            cnt_r <= cnt_r + W'(1);
         end
      end
   end

endmodule // settle_timer

// ---- dv/adc_ctrl_assertions.sv ----
// port-level checks of the converter control block
`timescale 1ns/1ns
module adc_ctrl_assertions
   import adc_ctrl_pkg::*;
#(
   parameter logic [5:0] DEV_CODE = 6'h01
) (
   input wire logic        clk_i,
   input wire logic        rst_n_i,
   input wire logic [5:0]  dev_sel_i,
   input wire logic [1:0]  subdev_sel_i,
   input wire logic        iop1_i,
   input wire logic        iop2_i,
   input wire logic        host_to_device_pulse_i,
   input wire logic [0:17] bus_data_n_i,
   input wire logic        dch_cycle_i,
   input wire logic        word_count_overflow_flag_i,
   input wire logic        mem_overflow_flag_i,
   input wire logic        ext_sync_i,
   input wire logic        conv_done_i,
   input wire logic        start_conv_o,
   input wire logic        settling_o,
   input wire logic [6:0]  channel_o,
   input wire logic [1:0]  gain_code_o,
   input wire ctrl_t       ctrl_o,
   input wire logic        done_flag_o,
   input wire logic        skip_o,
   input wire logic        clear_flags_o,
   input wire logic [0:17] bus_data_o,
   input wire logic        bus_data_oe_o
);
   // ***************
   // decode and checks
   // ***************
   wire        sel = !dch_cycle_i && dev_sel_i == DEV_CODE;
   wire [0:17] w   = ~bus_data_n_i;
   wire [6:0]  wch = w[11:17];
   wire [6:0]  wct = {w[10], w[9], w[4], w[5], w[6], w[7], w[8]};
   wire        cvt = sel && subdev_sel_i == 2'h0 && host_to_device_pulse_i && !iop1_i && !iop2_i;
   wire        rdb = sel && subdev_sel_i == 2'h0 && iop2_i && !iop1_i;
   wire        rds = sel && subdev_sel_i == 2'h1 && iop2_i && !iop1_i;
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i);
   sequence s_settle_end;
      settling_o ##1 !settling_o;
   endsequence
   chk_read_buf: assert property (rdb |=> bus_data_oe_o && bus_data_o[0:4] == 5'h00)
      else $error("read buffer word not driven");
   chk_read_stat: assert property (rds |=> bus_data_oe_o
      && bus_data_o == {$past(word_count_overflow_flag_i), $past(mem_overflow_flag_i), 9'h000, $past(channel_o)})
      else $error("status word wrong");
   chk_idle_zero: assert property (!bus_data_oe_o |-> bus_data_o == 18'h00000)
      else $error("bus driven without strobe");
   chk_skip_done: assert property (sel && subdev_sel_i == 2'h0 && iop1_i |-> skip_o == done_flag_o)
      else $error("skip on done wrong");
   chk_cvt_load: assert property (cvt |=> channel_o == $past(wch) && ctrl_o == $past(wct))
      else $error("convert did not load status word");
   chk_gain_map: assert property (cvt |=> gain_code_o == {$past(w[7]), $past(w[8])})
      else $error("gain code mismatch");
   chk_clear_flags: assert property (sel && subdev_sel_i == 2'h1 && host_to_device_pulse_i
      && !iop1_i && !iop2_i && !conv_done_i |-> clear_flags_o ##1 !done_flag_o)
      else $error("clear flags not decoded");
   chk_count_up: assert property (conv_done_i && ctrl_o.sequential_mode && ctrl_o.transfer_mode_ff
      && !word_count_overflow_flag_i && !host_to_device_pulse_i |=> channel_o == $past(channel_o) + 7'h01)
      else $error("channel did not advance");
   chk_settle_end: assert property (s_settle_end |-> start_conv_o)
      else $error("settle ended without start");
   chk_ext_sync: assert property (ctrl_o.ext_sync_sel && ext_sync_i |=> settling_o)
      else $error("external sync did not arm delay");
endmodule // adc_ctrl_assertions

bind multiplexed_adc_interface_control adc_ctrl_assertions #(.DEV_CODE(DEV_CODE)) chk_i (.*);

// ---- dv/host_bus_model.sv ----
// host i/o bus and data channel model
`timescale 1ns/1ns
module host_bus_model (
   input  wire logic        clk_i,
   input  wire logic        skip_i,
   input  wire logic [0:17] bus_data_i,
   input  wire logic        bus_data_oe_i,
   output logic [5:0]       dev_sel_o,
   output logic [1:0]       subdev_sel_o,
   output logic             iop1_o,
   output logic             iop2_o,
   output logic             h2d_o,
   output logic [0:17]      bus_data_n_o,
   output logic             dch_cycle_o,
   output logic             write_request_o,
   output logic             read_request_o
);
   logic        sk;
   logic        oe;
   logic [0:17] rd;
   initial begin
      {dev_sel_o, subdev_sel_o, iop1_o, iop2_o, h2d_o} = 11'h000;
      {dch_cycle_o, write_request_o, read_request_o} = 3'h0;
      bus_data_n_o = 18'h3ffff;
   end
   // ***************
   // one strobed transfer
   // ***************
   task automatic xfer(input logic d, input logic [5:0] dv, input logic [1:0] s, input logic [2:0] p,
                       input logic [0:17] w, input logic b);
      @(posedge clk_i);
      dch_cycle_o <= d;
      dev_sel_o <= dv;
      subdev_sel_o <= s;
      {iop1_o, iop2_o, h2d_o} <= p;
      bus_data_n_o <= ~w;
      {write_request_o, read_request_o} <= {b, b};
      @(negedge clk_i);
      sk = skip_i;
      @(posedge clk_i);
      {iop1_o, iop2_o, h2d_o} <= 3'h0;
      {dch_cycle_o, write_request_o, read_request_o} <= 3'h0;
      dev_sel_o <= ~dv;
      // released lines show the inverse so a stale word cannot pass
      bus_data_n_o <= w;
      @(negedge clk_i);
      rd = bus_data_i;
      oe = bus_data_oe_i;
   endtask
endmodule // host_bus_model

// ---- dv/tb.sv ----
// self-checking bench of the converter control block
`timescale 1ns/1ns
module tb;
   import adc_ctrl_pkg::*;
   localparam int         SETTLE = 4;
   localparam logic [2:0] P1 = 3'h4, P2 = 3'h2, P4 = 3'h1;
   logic        clk_i = 1'b0;
   logic        rst_n_i = 1'b0;
   logic        ext_sync_i = 1'b0;
   logic        conv_done_i = 1'b0;
   logic        wc = 1'b0;
   logic        mem = 1'b0;
   logic [12:0] conv_data = 13'h0000;
   logic [5:0]  dev = 6'h01;
   wire  [5:0]  dev_sel;
   wire  [1:0]  sub;
   wire         iop1, iop2, h2d, dch, wr, rq, oe, start, settling, skip, valid;
   wire  [0:17] bus_n, bus_q;
   wire  [6:0]  channel;
   wire  [1:0]  gain;
   wire ctrl_t  ctrl;
   int          fails = 0;
   int          n_compared = 0;
   int          n;
   always #20 clk_i = ~clk_i;
   host_bus_model hm (.clk_i(clk_i), .skip_i(skip), .bus_data_i(bus_q), .bus_data_oe_i(oe), .dev_sel_o(dev_sel),
      .subdev_sel_o(sub), .iop1_o(iop1), .iop2_o(iop2), .h2d_o(h2d), .bus_data_n_o(bus_n), .dch_cycle_o(dch),
      .write_request_o(wr), .read_request_o(rq));
   multiplexed_adc_interface_control #(.SETTLE(SETTLE), .MUX_CHANNELS(32)) dut (
      .clk_i(clk_i), .rst_n_i(rst_n_i), .dev_sel_i(dev_sel),
      .subdev_sel_i(sub), .iop1_i(iop1), .iop2_i(iop2), .host_to_device_pulse_i(h2d), .bus_data_n_i(bus_n),
      .dch_cycle_i(dch), .write_request_i(wr), .read_request_i(rq), .word_count_overflow_flag_i(wc),
      .mem_overflow_flag_i(mem), .ext_sync_i(ext_sync_i), .conv_done_i(conv_done_i), .conv_data_i(conv_data),
      .start_conv_o(start), .settling_o(settling), .channel_o(channel), .channel_valid_o(valid), .gain_code_o(gain),
      .ctrl_o(ctrl), .done_flag_o(), .skip_o(skip), .clear_flags_o(), .bus_data_o(bus_q), .bus_data_oe_o(oe));
   // ***************
   // helpers
   // ***************
   task automatic chk(input logic [18:0] g, input logic [18:0] e);
      n_compared++;
      if (g !== e) begin
         fails++;
         $display("[ERR] %0t got %h expected %h", $time, g, e);
      end
   endtask
   // f packs sequential, add, external sync, data channel, overflow enable
   function automatic logic [0:17] sw(input logic [4:0] f, input logic [1:0] g, input logic [6:0] ch);
      return {4'h0, f[2], f[1], f[0], g, f[3], f[4], ch};
   endfunction
   task automatic done(input logic [12:0] d);
      @(posedge clk_i);
      conv_done_i <= 1'b1;
      conv_data <= d;
      @(posedge clk_i);
      conv_done_i <= 1'b0;
      @(negedge clk_i);
   endtask
   task automatic flags(input logic w, input logic m);
      @(posedge clk_i);
      wc <= w;
      mem <= m;
   endtask
   task automatic wait_start();
      n = 0;
      while (start !== 1'b1 && n < 40) begin
         @(negedge clk_i);
         n++;
      end
   endtask
   task automatic stop_test();
      $display("compared %0d mismatches %0d", n_compared, fails);
      if (fails == 0 && n_compared > 0) begin
         $display("*** PASS ***");
      end else begin
         $display("*** FAIL ***");
      end
      $finish;
   endtask
   initial begin
      repeat (3000) @(posedge clk_i);
      fails++;
      stop_test();
   end
   initial begin
      repeat (12) @(posedge clk_i);
      rst_n_i <= 1'b1;
      @(negedge clk_i);
      chk({channel, ctrl, oe}, 18'h0);
      for (int g = 0; g < 4; g++) begin
         hm.xfer(1'b0, dev, 2'h0, P4, sw(5'h00, g[1:0], 7'h55 + g[6:0]), 1'b0);
         chk(gain, g[1:0]);
         chk(channel, 7'h55 + g[6:0]);
         chk(valid, 1'b0);
         chk(ctrl, g[1:0]);
      end
      wait_start();
      chk(n, SETTLE + 1);
      chk(settling, 1'b0);
      $display("convert test done");
      done(13'h1abc);
      hm.xfer(1'b0, dev, 2'h0, P1, 18'h0, 1'b0);
      chk(hm.sk, 1'b1);
      hm.xfer(1'b0, dev, 2'h0, P2, 18'h0, 1'b0);
      chk({hm.oe, hm.rd}, 19'h41abc);
      hm.xfer(1'b0, dev, 2'h0, P1, 18'h0, 1'b0);
      chk(hm.sk, 1'b0);
      flags(1'b0, 1'b1);
      done(13'h0123);
      hm.xfer(1'b0, dev, 2'h0, P2, 18'h0, 1'b0);
      chk(hm.rd, 18'h01abc);
      flags(1'b1, 1'b1);
      hm.xfer(1'b0, dev, 2'h1, P2, 18'h0, 1'b0);
      chk(hm.rd, 18'h30058);
      hm.xfer(1'b0, dev, 2'h1, P1, 18'h0, 1'b0);
      chk(hm.sk, 1'b1);
      hm.xfer(1'b0, dev, 2'h2, P1, 18'h0, 1'b0);
      chk(hm.sk, 1'b1);
      flags(1'b0, 1'b0);
      done(13'h0000);
      hm.xfer(1'b0, dev, 2'h1, P4, 18'h0, 1'b0);
      hm.xfer(1'b0, dev, 2'h0, P1, 18'h0, 1'b0);
      chk(hm.sk, 1'b0);
      hm.xfer(1'b0, dev, 2'h2, P1, 18'h0, 1'b0);
      chk(hm.sk, 1'b0);
      $display("result test done");
      hm.xfer(1'b0, dev, 2'h0, P4, sw(5'h12, 2'h0, 7'h7f), 1'b0);
      done(13'h0000);
      chk(channel, 7'h00);
      chk(valid, 1'b1);
      flags(1'b1, 1'b0);
      done(13'h0000);
      chk(channel, 7'h00);
      flags(1'b0, 1'b0);
      hm.xfer(1'b1, dev, 2'h0, P4, sw(5'h02, 2'h1, 7'h33), 1'b0);
      chk(channel, 7'h33);
      hm.xfer(1'b1, dev, 2'h0, P4, sw(5'h02, 2'h1, 7'h44), 1'b1);
      chk(channel, 7'h33);
      flags(1'b1, 1'b0);
      hm.xfer(1'b1, dev, 2'h0, P4, sw(5'h02, 2'h1, 7'h22), 1'b0);
      chk(channel, 7'h33);
      flags(1'b0, 1'b0);
      done(13'h0000);
      chk(channel, 7'h33);
      hm.xfer(1'b1, dev, 2'h0, P2, 18'h0, 1'b0);
      chk(hm.oe, 1'b1);
      hm.xfer(1'b0, 6'h02, 2'h0, P2, 18'h0, 1'b0);
      chk(hm.oe, 1'b0);
      $display("channel test done");
      hm.xfer(1'b0, dev, 2'h0, P4, sw(5'h04, 2'h0, 7'h01), 1'b0);
      repeat (8) @(posedge clk_i);
      ext_sync_i <= 1'b1;
      @(posedge clk_i);
      ext_sync_i <= 1'b0;
      wait_start();
      chk(n, SETTLE + 1);
      $display("sync test done");
      stop_test();
   end
endmodule // tb
